// ### include/tws_map.svh
// Register offsets, field positions, reset values, status codes and timing for the receiver
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define TWS_OFF_CTRL 8'h00
`define TWS_OFF_STATUS 8'h04
`define TWS_OFF_DATA 8'h08
`define TWS_OFF_IRQ_ST 8'h0C
`define TWS_OFF_IRQ_MASK 8'h10
`define TWS_OFF_OWN_ADDR 8'h14

// ************************************************************
// Control fields
// ************************************************************
`define TWS_CTRL_FLAG 0
`define TWS_CTRL_ACK 1
`define TWS_CTRL_START 2
`define TWS_CTRL_STOP 3
`define TWS_CTRL_EN 4
`define TWS_CTRL_MT 5

// ************************************************************
// Interrupt status fields
// ************************************************************
`define TWS_IRQ_EVENT 0
`define TWS_IRQ_ARB 1
`define TWS_IRQ_STOP 2

// ************************************************************
// Reset values
// ************************************************************
`define TWS_RST_STATUS 8'hF8
`define TWS_RST_DATA 8'hFF
`define TWS_RST_IRQ 3'h0
`define TWS_RST_OWN 8'h00

// ************************************************************
// Bus status codes
// ************************************************************
`define TWS_SC_START 8'h08
`define TWS_SC_RSTART 8'h10
`define TWS_SC_W_ACK 8'h18
`define TWS_SC_W_NACK 8'h20
`define TWS_SC_ARB 8'h38
`define TWS_SC_R_ACK 8'h40
`define TWS_SC_R_NACK 8'h48
`define TWS_SC_D_ACK 8'h50
`define TWS_SC_D_NACK 8'h58

// ************************************************************
// Timing: one quarter of a serial bit, least time
// ************************************************************
`define TWS_CLK_MHZ 40
`define TWS_QTR_NS 2500
`define TWS_QTR_CYC ((`TWS_QTR_NS * `TWS_CLK_MHZ + 999) / 1000)
`define TWS_QTR_LAST 8'(`TWS_QTR_CYC - 1)

`endif

// ### include/tws_pkg.sv
// Types shared by the two-wire master receiver sequencer
package tws_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WFREE,
    ST_START,
    ST_BITS,
    ST_STOP,
    ST_HOLD
  } tws_state_t;

  // Control register image, bit 5 downward
  typedef struct packed {
    logic mt_mode;
    logic enable;
    logic stop_req;
    logic start_req;
    logic ack_en;
    logic event_flag;
  } tws_ctrl_t;

  typedef struct packed {
    logic scl_low;
    logic sda_low;
  } tws_line_t;

endpackage

// ### rtl/tws_master_rx.sv
// Two-wire master receiver sequencer with AHB-Lite register slave
//
// Overview of operation
// - After START post $08; software loads read address; device sends it, samples ack.
// - After repeated START post $10; read address continues, write address enters transmitter.
// - Arbitration lost in address or NOT ACK bit posts $38; no start releases bus.
// - $38 answered with start request waits for free bus, then sends START.
// - $40 read address acked; receive byte, answer ACK if ack enable set.
// - $48 read address not acked; start, stop, or stop then start per bits.
// - $50 byte received with ACK; ack enable picks ACK for next byte.
// - $58 byte received with NOT ACK; start/stop bits choose next action like $48.
// - Device clears stop request bit itself after putting STOP on the bus.
// - Each status point sets event flag and holds code; all but $38 suspend bus until cleared.
`timescale 1ns/1ps
`include "tws_map.svh"

module tws_master_rx (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Serial bus, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Interrupt
  output logic irq_o
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r, scl_d_r, sda_d_r;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      scl_d_r <= scl_s2_r;
      sda_d_r <= sda_s2_r;
    end
  end

  // ************************************************************
  // State
  // ************************************************************
  tws_pkg::tws_state_t st_r, st_nxt;
  tws_pkg::tws_ctrl_t ctrl_r, ctrl_nxt;
  tws_pkg::tws_line_t line_r, line_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [7:0] tick_r, tick_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic is_addr_r, is_addr_nxt;
  logic rd_dir_r, rd_dir_nxt;
  logic ack_bit_r, ack_bit_nxt;
  logic ack_seen_r, ack_seen_nxt;
  logic sta_pend_r, sta_pend_nxt;
  logic rep_r, rep_nxt;
  logic busy_r, busy_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] own_r, own_nxt;
  logic [2:0] irq_st_r, irq_st_nxt;
  logic [2:0] irq_mask_r, irq_mask_nxt;
  logic irq_r, irq_nxt;
  logic a_wr_r, a_wr_nxt;
  logic [7:0] a_off_r, a_off_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // Scratch values of the combinational process
  logic a_take, wr_ctrl, flag_clear, q_done, arb, post;
  logic [2:0] ev_set;
  logic [7:0] post_code;
  tws_pkg::tws_ctrl_t wctrl;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    ctrl_nxt = ctrl_r;
    line_nxt = line_r;
    ph_nxt = ph_r;
    tick_nxt = tick_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    is_addr_nxt = is_addr_r;
    rd_dir_nxt = rd_dir_r;
    ack_bit_nxt = ack_bit_r;
    ack_seen_nxt = ack_seen_r;
    sta_pend_nxt = sta_pend_r;
    rep_nxt = rep_r;
    status_nxt = status_r;
    data_nxt = data_r;
    own_nxt = own_r;
    irq_mask_nxt = irq_mask_r;
    rdata_nxt = rdata_r;
    ev_set = 3'h0;
    post = 1'b0;
    post_code = status_r;
    arb = 1'b0;
    wctrl = tws_pkg::tws_ctrl_t'(hwdata_i[5:0]);

    // Bus free watch from START and STOP seen on the lines
    busy_nxt = busy_r;
    if (scl_s2_r && sda_d_r && !sda_s2_r) begin
      busy_nxt = 1'b1;
    end else if (scl_s2_r && !sda_d_r && sda_s2_r) begin
      busy_nxt = 1'b0;
    end

    // AHB-Lite address phase; data phase has no wait states
    a_take = hsel_i && htrans_i[1] && hready_i;
    a_wr_nxt = a_take && hwrite_i;
    a_off_nxt = a_take ? haddr_i[7:0] : 8'h00;
    if (a_take && !hwrite_i) begin
      case (haddr_i[7:0])
        `TWS_OFF_CTRL: rdata_nxt = {26'h0, ctrl_r};
        `TWS_OFF_STATUS: rdata_nxt = {24'h0, status_r};
        `TWS_OFF_DATA: rdata_nxt = {24'h0, data_r};
        `TWS_OFF_IRQ_ST: rdata_nxt = {29'h0, irq_st_r};
        `TWS_OFF_IRQ_MASK: rdata_nxt = {29'h0, irq_mask_r};
        `TWS_OFF_OWN_ADDR: rdata_nxt = {24'h0, own_r};
        default: rdata_nxt = 32'h0;
      endcase
    end

    // Register writes in the data phase
    wr_ctrl = a_wr_r && (a_off_r == `TWS_OFF_CTRL);
    flag_clear = wr_ctrl && wctrl.event_flag && ctrl_r.event_flag;
    if (wr_ctrl) begin
      ctrl_nxt.ack_en = wctrl.ack_en;
      ctrl_nxt.start_req = wctrl.start_req;
      ctrl_nxt.stop_req = wctrl.stop_req;
      ctrl_nxt.enable = wctrl.enable;
      if (wctrl.event_flag) begin
        ctrl_nxt.event_flag = 1'b0;
      end
    end
    if (a_wr_r && a_off_r == `TWS_OFF_DATA) begin
      data_nxt = hwdata_i[7:0];
    end
    if (a_wr_r && a_off_r == `TWS_OFF_IRQ_MASK) begin
      irq_mask_nxt = hwdata_i[2:0];
    end
    if (a_wr_r && a_off_r == `TWS_OFF_OWN_ADDR) begin
      own_nxt = hwdata_i[7:0];
    end

    // Quarter-bit timer; a high phase waits while a slave stretches the clock
    q_done = (tick_r == `TWS_QTR_LAST);
    if (st_r == tws_pkg::ST_IDLE || st_r == tws_pkg::ST_WFREE || st_r == tws_pkg::ST_HOLD) begin
      tick_nxt = 8'h00;
    end else if (ph_r == 2'd1 && !scl_s2_r) begin
      tick_nxt = 8'h00;
    end else begin
      tick_nxt = q_done ? 8'h00 : tick_r + 8'h01;
    end

    case (st_r)
      tws_pkg::ST_IDLE: begin
        line_nxt = '0;
        if (ctrl_r.enable && ctrl_r.start_req && !ctrl_r.event_flag) begin
          st_nxt = tws_pkg::ST_WFREE;
        end
      end
      tws_pkg::ST_WFREE: begin
        if (!busy_r) begin
          st_nxt = tws_pkg::ST_START;
          ph_nxt = 2'd0;
        end
      end
      tws_pkg::ST_START: begin
        // Same sequence serves a first and a repeated START
        case (ph_r)
          2'd0: line_nxt.sda_low = 1'b0;
          2'd1: line_nxt.scl_low = 1'b0;
          2'd2: line_nxt.sda_low = 1'b1;
          default: line_nxt.scl_low = 1'b1;
        endcase
        if (q_done) begin
          ph_nxt = ph_r + 2'd1;
          if (ph_r == 2'd3) begin
            post = 1'b1;
            post_code = rep_r ? `TWS_SC_RSTART : `TWS_SC_START;
            rep_nxt = 1'b1;
          end
        end
      end
      tws_pkg::ST_BITS: begin
        case (ph_r)
          2'd0: begin
            line_nxt.scl_low = 1'b1;
            if (bit_r == 4'd8) begin
              line_nxt.sda_low = !is_addr_r && ack_bit_r;
            end else begin
              line_nxt.sda_low = is_addr_r && !sh_r[7];
            end
          end
          2'd1: line_nxt.scl_low = 1'b0;
          2'd2: begin
            line_nxt.scl_low = 1'b0;
            // Lost if a released one reads back low, in address or NOT ACK bit
            arb = q_done && !sda_s2_r &&
                  ((is_addr_r && bit_r != 4'd8 && sh_r[7]) ||
                   (!is_addr_r && bit_r == 4'd8 && !ack_bit_r));
            if (q_done && !arb) begin
              if (bit_r == 4'd8) begin
                ack_seen_nxt = !sda_s2_r;
              end else begin
                sh_nxt = {sh_r[6:0], sda_s2_r};
              end
            end
          end
          default: line_nxt.scl_low = 1'b1;
        endcase
        if (arb) begin
          line_nxt = '0;
          rep_nxt = 1'b0;
          post = 1'b1;
          post_code = `TWS_SC_ARB;
          ev_set[`TWS_IRQ_ARB] = 1'b1;
        end else if (q_done) begin
          ph_nxt = ph_r + 2'd1;
          if (ph_r == 2'd3) begin
            bit_nxt = bit_r + 4'd1;
            if (bit_r == 4'd8) begin
              post = 1'b1;
              if (is_addr_r && rd_dir_r) begin
                post_code = ack_seen_r ? `TWS_SC_R_ACK : `TWS_SC_R_NACK;
              end else if (is_addr_r) begin
                ctrl_nxt.mt_mode = 1'b1;
                post_code = ack_seen_r ? `TWS_SC_W_ACK : `TWS_SC_W_NACK;
              end else begin
                data_nxt = sh_r;
                post_code = ack_bit_r ? `TWS_SC_D_ACK : `TWS_SC_D_NACK;
              end
            end
          end
        end
      end
      tws_pkg::ST_STOP: begin
        case (ph_r)
          2'd0: line_nxt = '{scl_low: 1'b1, sda_low: 1'b1};
          2'd1: line_nxt.scl_low = 1'b0;
          2'd2: line_nxt.sda_low = 1'b0;
          default: line_nxt = '0;
        endcase
        if (q_done) begin
          ph_nxt = ph_r + 2'd1;
          if (ph_r == 2'd3) begin
            ctrl_nxt.stop_req = 1'b0;
            ctrl_nxt.mt_mode = 1'b0;
            rep_nxt = 1'b0;
            ev_set[`TWS_IRQ_STOP] = 1'b1;
            st_nxt = sta_pend_r ? tws_pkg::ST_WFREE : tws_pkg::ST_IDLE;
            sta_pend_nxt = 1'b0;
          end
        end
      end
      tws_pkg::ST_HOLD: begin
        // Bus frozen with the clock held low until the flag is cleared, except after $38, where both lines are released
        if (flag_clear) begin
          ph_nxt = 2'd0;
          bit_nxt = 4'd0;
          // Bits are taken from the very write that clears the flag
          case (status_r)
            `TWS_SC_START, `TWS_SC_RSTART: begin
              st_nxt = tws_pkg::ST_BITS;
              is_addr_nxt = 1'b1;
              sh_nxt = data_r;
              rd_dir_nxt = data_r[0];
            end
            `TWS_SC_ARB: begin
              st_nxt = wctrl.start_req ? tws_pkg::ST_WFREE : tws_pkg::ST_IDLE;
              ctrl_nxt.mt_mode = 1'b0;
            end
            `TWS_SC_R_ACK, `TWS_SC_D_ACK: begin
              st_nxt = tws_pkg::ST_BITS;
              is_addr_nxt = 1'b0;
              ack_bit_nxt = wctrl.ack_en;
            end
            default: begin
              sta_pend_nxt = wctrl.start_req && wctrl.stop_req;
              if (wctrl.stop_req) begin
                st_nxt = tws_pkg::ST_STOP;
              end else if (wctrl.start_req) begin
                st_nxt = tws_pkg::ST_START;
              end else begin
                st_nxt = tws_pkg::ST_IDLE;
              end
            end
          endcase
        end
      end
      default: st_nxt = tws_pkg::ST_IDLE;
    endcase

    // Status point: code held, flag raised, sequencer parked
    if (post) begin
      status_nxt = post_code;
      ctrl_nxt.event_flag = 1'b1;
      ev_set[`TWS_IRQ_EVENT] = 1'b1;
      st_nxt = tws_pkg::ST_HOLD;
    end

    if (!ctrl_r.enable && !(wr_ctrl && wctrl.enable)) begin
      st_nxt = tws_pkg::ST_IDLE;
      line_nxt = '0;
      rep_nxt = 1'b0;
    end

    // Sticky events; a new event wins over a write-one clear
    irq_st_nxt = irq_st_r;
    if (a_wr_r && a_off_r == `TWS_OFF_IRQ_ST) begin
      irq_st_nxt = irq_st_r & ~hwdata_i[2:0];
    end
    irq_st_nxt = irq_st_nxt | ev_set;
    irq_nxt = |(irq_st_nxt & irq_mask_nxt);
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_r <= tws_pkg::ST_IDLE;
      ctrl_r <= '0;
      line_r <= '0;
      ph_r <= 2'd0;
      tick_r <= 8'h00;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      is_addr_r <= 1'b0;
      rd_dir_r <= 1'b0;
      ack_bit_r <= 1'b0;
      ack_seen_r <= 1'b0;
      sta_pend_r <= 1'b0;
      rep_r <= 1'b0;
      busy_r <= 1'b0;
      status_r <= `TWS_RST_STATUS;
      data_r <= `TWS_RST_DATA;
      own_r <= `TWS_RST_OWN;
      irq_st_r <= `TWS_RST_IRQ;
      irq_mask_r <= `TWS_RST_IRQ;
      irq_r <= 1'b0;
      a_wr_r <= 1'b0;
      a_off_r <= 8'h00;
      rdata_r <= 32'h0;
    end else begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      line_r <= line_nxt;
      ph_r <= ph_nxt;
      tick_r <= tick_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      is_addr_r <= is_addr_nxt;
      rd_dir_r <= rd_dir_nxt;
      ack_bit_r <= ack_bit_nxt;
      ack_seen_r <= ack_seen_nxt;
      sta_pend_r <= sta_pend_nxt;
      rep_r <= rep_nxt;
      busy_r <= busy_nxt;
      status_r <= status_nxt;
      data_r <= data_nxt;
      own_r <= own_nxt;
      irq_st_r <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r <= irq_nxt;
      a_wr_r <= a_wr_nxt;
      a_off_r <= a_off_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Open-drain pins only ever pull low, so the data outputs stay at zero
  assign scl_oe_o = line_r.scl_low;
  assign sda_oe_o = line_r.sda_low;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign hrdata_o = rdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign irq_o = irq_r;

endmodule

// ### verification/tws_master_rx_sva.sv
// Checker for bus answers and serial-line holding of the receiver
`timescale 1ns/1ps
`include "tws_map.svh"
module tws_master_rx_sva (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Serial lines
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic take;
  logic wr_r;
  logic wr_nxt;
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;
  assign take = hsel_i & htrans_i[1] & hready_i;
  // Normal SCL low lasts two quarters; longer than that is a status hold
  always_comb begin
    hold_nxt = (hold_r == 8'hFF) ? hold_r : hold_r + 8'h01;
    wr_nxt = wr_r | (take & hwrite_i & (haddr_i[7:0] == `TWS_OFF_CTRL));
    if (!scl_oe_o) begin
      hold_nxt = 8'h00;
      wr_nxt = 1'b0;
    end
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      hold_r <= 8'h00;
      wr_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      wr_r <= wr_nxt;
    end
  end
  property p_okay; hresp_o == 1'b0 && hreadyout_o == 1'b1; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready OKAY");
  property p_od; scl_o == 1'b0 && sda_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("open-drain level not low");
  property p_hold_scl; hold_r > 8'hDC && !wr_r |=> scl_oe_o; endproperty
  a_hold_scl: assert property (p_hold_scl) else $error("SCL freed in hold");
  property p_hold_sda; hold_r > 8'hDC && !wr_r |=> $stable(sda_oe_o); endproperty
  a_hold_sda: assert property (p_hold_sda) else $error("SDA moved in hold");
  property p_rd_keep; !(take && !hwrite_i) |=> $stable(hrdata_o); endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("read data moved");
  property p_unmapped;
    take && !hwrite_i && haddr_i[7:0] > 8'h17 |=> hrdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_start_gap;
    $rose(sda_oe_o) && !scl_oe_o && scl_i |=> !scl_oe_o [*8];
  endproperty
  a_start_gap: assert property (p_start_gap) else $error("START too short");
  property p_stop_free;
    $fell(sda_oe_o) && !scl_oe_o && scl_i |=> !scl_oe_o [*8];
  endproperty
  a_stop_free: assert property (p_stop_free) else $error("SCL taken after STOP");
  c_hold: cover property (hold_r > 8'hDC);
  c_start: cover property ($rose(sda_oe_o) && !scl_oe_o && scl_i);
  c_stop: cover property ($fell(sda_oe_o) && !scl_oe_o && scl_i);
endmodule
bind tws_master_rx tws_master_rx_sva tws_master_rx_sva_i (
  .clock_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
  .hreadyout_o, .hresp_o, .scl_i, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o
);

// ### verification/tws_slave_model.sv
// Behavioural slave on the two-wire bus, with a forced clash for arbitration
`timescale 1ns/1ps
module tws_slave_model #(
  parameter logic [6:0] ADDR = 7'h5A
) (
  // Clock and wire levels
  input wire logic clock_i,
  input wire logic scl_i,
  input wire logic sda_i,
  // Bench control
  input wire logic clash_i,
  input wire logic [7:0] tx_i,
  // Drive and capture
  output logic sda_low_o,
  output logic [7:0] addr_o,
  output logic ack_o
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic drv = 1'b0;
  logic [1:0] ph = 2'd0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx_r = 8'h00;
  initial addr_o = 8'h00;
  initial ack_o = 1'b0;
  // Clash holds SDA low until the bench lets go, which then reads as STOP
  assign sda_low_o = drv | (clash_i & (ph == 2'd1));
  always @(posedge clock_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (scl_i && scl_q && sda_q != sda_i) begin
      ph <= sda_i ? 2'd0 : 2'd1;
      cnt <= 4'h0;
      drv <= 1'b0;
    end else if (scl_i && !scl_q) begin
      cnt <= cnt + 4'h1;
      if (ph == 2'd1 && cnt < 4'h8) sh <= {sh[6:0], sda_i};
      if (cnt == 4'h8) ack_o <= !sda_i;
    end else if (!scl_i && scl_q && ph != 2'd0) begin
      if (cnt == 4'h8) begin
        drv <= (ph == 2'd1) ? (sh[7:1] == ADDR) : 1'b0;
        if (ph == 2'd1) addr_o <= sh;
      end else if (cnt == 4'h9) begin
        cnt <= 4'h0;
        if ((ph == 2'd1 && drv && sh[0]) || (ph == 2'd2 && ack_o)) begin
          ph <= 2'd2;
          tx_r <= tx_i;
          drv <= !tx_i[7];
        end else begin
          ph <= 2'd0;
          drv <= 1'b0;
        end
      end else if (ph == 2'd2) begin
        drv <= !tx_r[7 - cnt];
      end
    end
  end
endmodule

// ### verification/tws_master_rx_tb_top.sv
// Self-checking bench for the master receiver sequencer
`timescale 1ns/1ps
`include "tws_map.svh"
module tws_master_rx_tb_top;
  localparam logic [6:0] ADDR = 7'h5A;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic clash = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] d;
  logic [7:0] tx = 8'h00;
  logic [7:0] exp;
  logic [7:0] seen_addr;
  logic hready, hresp, scl_oe, sda_oe, sda_low, irq, ack, scl_w, sda_w;
  int errors = 0;
  int num_checks = 0;
  int seed;
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe | sda_low);
  initial begin
    forever #12.5 clock_i = !clock_i;
  end
  tws_master_rx tws_master_rx_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .scl_i(scl_w), .scl_o(),
    .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .irq_o(irq)
  );
  tws_slave_model #(.ADDR(ADDR)) tws_slave_model_i (
    .clock_i(clock_i), .scl_i(scl_w), .sda_i(sda_w), .clash_i(clash), .tx_i(tx),
    .sda_low_o(sda_low), .addr_o(seen_addr), .ack_o(ack)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic chk1(input logic seen, input logic want);
    chk({31'h0, seen}, {31'h0, want});
  endtask
  // Status expected after a received byte, from the acknowledge that was asked for
  function automatic logic [7:0] data_code(input logic ak);
    return ak ? `TWS_SC_D_ACK : `TWS_SC_D_NACK;
  endfunction
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] v,
      output logic [31:0] r);
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clock_i); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    ahb(1'b1, a, v, x);
  endtask
  task automatic go(input logic stop_request_bit, input logic start_request_bit, input logic ak);
    wr(`TWS_OFF_CTRL, {27'h0, 1'b1, stop_request_bit, start_request_bit, ak, 1'b1});
  endtask
  task automatic wflag(input logic [7:0] code);
    d = 32'h0;
    while (d[0] !== 1'b1) rd(`TWS_OFF_CTRL);
    rd(`TWS_OFF_STATUS);
    chk(d, {24'h0, code});
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clock_i);
    errors++;
    summarize();
  end
  initial begin
    seed = 32'hCE2DF943;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(`TWS_OFF_STATUS);
    chk(d, {24'h0, `TWS_RST_STATUS});
    rd(`TWS_OFF_DATA);
    chk(d, {24'h0, `TWS_RST_DATA});
    rd(8'h20);
    chk(d, 32'h0);
    chk1(hresp, 1'b0);
    exp = 8'($random(seed));
    wr(`TWS_OFF_OWN_ADDR, {24'h0, exp});
    rd(`TWS_OFF_OWN_ADDR);
    chk(d, {24'h0, exp});
    $display("reset values done");
    tx <= 8'($random(seed));
    go(1'b0, 1'b1, 1'b0);
    wflag(`TWS_SC_START);
    chk1(irq, 1'b0);
    wr(`TWS_OFF_IRQ_MASK, 32'h1);
    repeat (4) @(posedge clock_i);
    chk1(irq, 1'b1);
    repeat (300) @(posedge clock_i);
    rd(`TWS_OFF_CTRL);
    chk1(d[0], 1'b1);
    chk1(scl_oe, 1'b1);
    wr(`TWS_OFF_IRQ_ST, 32'h1);
    repeat (4) @(posedge clock_i);
    chk1(irq, 1'b0);
    $display("start and interrupt done");
    wr(`TWS_OFF_DATA, {24'h0, ADDR, 1'b1});
    go(1'b0, 1'b0, 1'b0);
    wflag(`TWS_SC_R_ACK);
    chk({24'h0, seen_addr}, {24'h0, ADDR, 1'b1});
    for (int i = 0; i < 4; i++) begin
      exp = tx;
      tx <= 8'($random(seed));
      go(1'b0, 1'b0, i < 3);
      wflag(data_code(i < 3));
      rd(`TWS_OFF_DATA);
      chk({24'h0, d[7:0]}, {24'h0, exp});
      chk1(ack, i < 3);
    end
    go(1'b1, 1'b1, 1'b0);
    wflag(`TWS_SC_START);
    rd(`TWS_OFF_CTRL);
    chk1(d[3], 1'b0);
    $display("receive done");
    wr(`TWS_OFF_DATA, {24'h0, ADDR ^ 7'h01, 1'b1});
    go(1'b0, 1'b0, 1'b0);
    wflag(`TWS_SC_R_NACK);
    go(1'b0, 1'b1, 1'b0);
    wflag(`TWS_SC_RSTART);
    wr(`TWS_OFF_DATA, {24'h0, ADDR, 1'b1});
    go(1'b0, 1'b0, 1'b0);
    wflag(`TWS_SC_R_ACK);
    exp = tx;
    go(1'b0, 1'b0, 1'b0);
    wflag(`TWS_SC_D_NACK);
    rd(`TWS_OFF_DATA);
    chk({24'h0, d[7:0]}, {24'h0, exp});
    go(1'b0, 1'b1, 1'b0);
    wflag(`TWS_SC_RSTART);
    wr(`TWS_OFF_DATA, {24'h0, ADDR, 1'b0});
    go(1'b0, 1'b0, 1'b0);
    wflag(`TWS_SC_W_ACK);
    rd(`TWS_OFF_CTRL);
    chk1(d[5], 1'b1);
    go(1'b1, 1'b0, 1'b0);
    repeat (1000) @(posedge clock_i);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    rd(`TWS_OFF_CTRL);
    chk({28'h0, d[3:0]}, 32'h0);
    $display("repeated start and stop done");
    go(1'b0, 1'b1, 1'b0);
    wflag(`TWS_SC_START);
    wr(`TWS_OFF_DATA, {24'h0, ADDR, 1'b1});
    clash <= 1'b1;
    go(1'b0, 1'b0, 1'b0);
    wflag(`TWS_SC_ARB);
    rd(`TWS_OFF_IRQ_ST);
    chk1(d[`TWS_IRQ_ARB], 1'b1);
    go(1'b0, 1'b0, 1'b0);
    repeat (400) @(posedge clock_i);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    go(1'b0, 1'b1, 1'b0);
    repeat (1000) @(posedge clock_i);
    rd(`TWS_OFF_CTRL);
    chk1(d[0], 1'b0);
    chk1(sda_oe, 1'b0);
    clash <= 1'b0;
    wflag(`TWS_SC_START);
    $display("arbitration done");
    summarize();
  end
endmodule
